// ### inc/kms_pkg.sv
// Constants, register map and types for the key matrix scanner.
// Behaviour
// - Scan keys sequentially, at most 8x20 matrix.
// - Programmable active rows and columns bound scans.
// - Sixteen entry key code buffer holds keys.
// - Scan steps run at 128 kHz tick.
// - Report all keys except masked modifiers; ghost locks the ghost key.
// - Codes kept until read; overflow drops new.
// - Row inputs debounced and glitch filtered.
// - Three states; Idle after reset.
// - Idle drives columns high, watches rows.
// - Row change in Idle requests clock, scans.
// - Idle clears row-hit and key index.
// - Row counter wraps, then column advances.
// - Both terminal counts move to Scan End.
// - Key index advances per scanned position.
// - Multi-hit column ORs rows into accumulator.
// - Hit in earlier multi-hit column's row sets ghost.
// - Scan End rescans if keys, else Idle.
// - Host polls key status register.
package kms_pkg;

  localparam int unsigned MAX_ROWS  = 8;
  localparam int unsigned MAX_COLS  = 20;
  localparam int unsigned BUF_DEPTH = 16;

  // Timing: scan tick rate derived from the core clock.
  localparam int unsigned CLK_HZ      = 25000000;
  localparam int unsigned SCAN_HZ     = 128000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / SCAN_HZ;

  // Register byte offsets on APB.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DATA   = 8'h08;
  localparam logic [7:0] OFS_MOD0   = 8'h0C;
  localparam logic [7:0] OFS_MOD1   = 8'h10;

  // Control field positions and reset values.
  localparam int unsigned CTRL_ROWS_LSB = 0;
  localparam int unsigned CTRL_COLS_LSB = 4;
  localparam int unsigned CTRL_EN_BIT   = 12;
  localparam logic [3:0] RST_ROWS = 4'h8;
  localparam logic [4:0] RST_COLS = 5'h14;

  // Status field positions.
  localparam int unsigned ST_CNT_LSB   = 0;
  localparam int unsigned ST_EMPTY_BIT = 8;
  localparam int unsigned ST_FULL_BIT  = 9;
  localparam int unsigned ST_OVF_BIT   = 10;
  localparam int unsigned ST_GHOST_BIT = 11;
  localparam int unsigned ST_ACT_BIT   = 12;
  localparam int unsigned ST_CLKR_BIT  = 13;
  localparam int unsigned ST_STATE_LSB = 16;

  typedef enum logic [1:0] {KMS_IDLE, KMS_SCAN, KMS_SCAN_END} kms_state_t;

  // One key event as stored in the buffer.
  typedef struct packed {
    logic       release_evt;
    logic [7:0] index;
  } kms_code_t;

endpackage : kms_pkg

// ### hw/kms_scanner.sv
// Key matrix scanner with APB register access.
`timescale 1ns/100ps
module kms_scanner
  import kms_pkg::*;
#(
  parameter int unsigned DEBOUNCE_SCANS = 3,
  parameter int unsigned TICK_DIV       = TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  // APB slave.
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Key matrix.
  output logic      [MAX_COLS-1:0] col_drive,
  input  wire logic [MAX_ROWS-1:0] row_in,
  // Clock request to the shared low speed clock source.
  input  wire logic                lsclk_busy,
  output logic                     lsclk_req
);

  // Three-stage synchroniser; the first stage feeds only the second.
  logic [MAX_ROWS-1:0] row_s1, row_s2, row_s3;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      row_s1 <= '0;
      row_s2 <= '0;
      row_s3 <= '0;
    end else begin
      row_s1 <= row_in;
      row_s2 <= row_s1;
      row_s3 <= row_s2;
    end
  end

  // Glitch filter: a row level counts only when stages two and three agree.
  logic [MAX_ROWS-1:0] row_f;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      row_f <= '0;
    end else begin
      for (int i = 0; i < MAX_ROWS; i++) begin
        if (row_s2[i] == row_s3[i]) begin
          row_f[i] <= row_s2[i];
        end
      end
    end
  end

  // Registers.
  logic [3:0]  cfg_rows;
  logic [4:0]  cfg_cols;
  logic        cfg_en;
  logic [63:0] mod_mask;
  logic        ovf;
  logic        ghost;

  // Scan state.
  kms_state_t  state;
  logic [$clog2(TICK_DIV+1)-1:0] tick_cnt;
  logic        tick;
  logic [2:0]  row_cnt;
  logic [4:0]  col_cnt;
  logic [7:0]  key_idx;
  logic [7:0]  row_hit;
  logic [7:0]  col_acc;
  logic        any_key;
  logic [MAX_ROWS-1:0] idle_ref;

  // Debounce state per key position, and accepted level.
  localparam int unsigned NKEYS = MAX_ROWS * MAX_COLS;
  localparam int unsigned DBW   = $clog2(DEBOUNCE_SCANS + 1);
  logic [DBW-1:0]   db_cnt [NKEYS];
  logic [NKEYS-1:0] key_state;
  logic [NKEYS-1:0] key_lock;

  // Buffer.
  kms_code_t buf_mem [BUF_DEPTH];
  logic [3:0] wr_ptr, rd_ptr;
  logic [4:0] fill;

  // Column decode for the column drive register.
  function automatic logic [MAX_COLS-1:0] col_onehot(input logic [4:0] c);
    col_onehot = '0;
    if (c < 5'(MAX_COLS)) begin
      col_onehot[c] = 1'b1;
    end
  endfunction : col_onehot

  // Address match helper used by the read and write paths.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  // APB decode; slave always answers in the access cycle.
  logic apb_wr, apb_rd;
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & penable & ~pwrite;

  // Scan tick generator; runs only while the clock is requested.
  // A new column needs one edge to reach the pins, three synchroniser edges and
  // one filter edge before its rows show in row_f.
  // TICK_DIV below six would therefore sample row zero of a column with the
  // previous column's data, so slow sim settings must stay at six or more.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (!lsclk_req) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (tick_cnt == ($bits(tick_cnt))'(TICK_DIV - 1)) begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick     <= 1'b0;
    end
  end

  // Current sampled key and its flat index.
  logic       cur_hit;
  logic [7:0] flat;
  assign cur_hit = row_f[row_cnt];
  assign flat    = 8'(col_cnt * MAX_ROWS + row_cnt);

  // Debounced decision on this position after the scan sample.
  logic db_done;
  logic is_mod;
  assign db_done = (db_cnt[flat] == DBW'(DEBOUNCE_SCANS - 1)) && (cur_hit != key_state[flat]);
  assign is_mod  = mod_mask[key_idx[5:0]] && (key_idx < 8'h40);

  // Ghost test: hit here while an earlier multi-hit column used this row.
  logic ghost_now;
  assign ghost_now = (state == KMS_SCAN) && tick && cur_hit && row_hit[row_cnt];

  // New key event towards the buffer.
  logic push;
  assign push = (state == KMS_SCAN) && tick && db_done && !key_lock[flat] && !ghost_now && !is_mod;

  // State machine and scan counters.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= KMS_IDLE;
      row_cnt   <= '0;
      col_cnt   <= '0;
      key_idx   <= '0;
      row_hit   <= '0;
      col_acc   <= '0;
      any_key   <= 1'b0;
      lsclk_req <= 1'b0;
      idle_ref  <= '0;
    end else begin
      case (state)
        KMS_IDLE: begin
          row_cnt  <= '0;
          col_cnt  <= '0;
          key_idx  <= '0;
          row_hit  <= '0;
          col_acc  <= '0;
          any_key  <= 1'b0;
          idle_ref <= row_f;
          if (cfg_en && (row_f != idle_ref)) begin
            lsclk_req <= ~lsclk_busy;
            state     <= KMS_SCAN;
          end
        end
        KMS_SCAN: begin
          if (lsclk_busy) begin
            lsclk_req <= 1'b1;
          end
          if (tick) begin
            key_idx <= key_idx + 1'b1;
            if (cur_hit || key_state != '0) begin
              any_key <= 1'b1;
            end
            if (row_cnt == 3'(cfg_rows - 1'b1)) begin
              row_cnt <= '0;
              // The index jumps to the next column's first position, so it always
              // equals col*8+row even when fewer rows are active.
              key_idx <= 8'((col_cnt + 5'h01) * MAX_ROWS);
              // Fold a multi-hit column into the accumulator.
              if ($countones(col_acc | ({7'h00, cur_hit} << row_cnt)) >= 2 ||
                  $countones(row_f & (8'hFF >> (8 - cfg_rows))) >= 2) begin
                row_hit <= row_hit | row_f;
              end
              col_acc <= '0;
              if (col_cnt == 5'(cfg_cols - 1'b1)) begin
                col_cnt <= '0;
                state   <= KMS_SCAN_END;
              end else begin
                col_cnt <= col_cnt + 1'b1;
              end
            end else begin
              row_cnt <= row_cnt + 1'b1;
              // Each row keeps its own bit, so two hits in a column count as two.
              col_acc <= col_acc | ({7'h00, cur_hit} << row_cnt);
            end
          end
        end
        KMS_SCAN_END: begin
          key_idx <= '0;
          row_hit <= '0;
          if (any_key) begin
            any_key <= 1'b0;
            state   <= KMS_SCAN;
          end else begin
            lsclk_req <= 1'b0;
            idle_ref  <= row_f;
            state     <= KMS_IDLE;
          end
        end
        default: state <= KMS_IDLE;
      endcase
    end
  end

  // Columns: all high in Idle, only the scanned column high in Scan.
  // Scan End keeps the first column driven when another pass follows; an
  // all-high cycle there would delay the first sample of the new pass.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      col_drive <= '1;
    end else if (state == KMS_SCAN || (state == KMS_SCAN_END && any_key)) begin
      col_drive <= col_onehot(col_cnt);
    end else begin
      col_drive <= '1;
    end
  end

  // Per-key debounce counters, one per matrix position.
  for (genvar k = 0; k < NKEYS; k++) begin : g_db
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        db_cnt[k]    <= '0;
        key_state[k] <= 1'b0;
        key_lock[k]  <= 1'b0;
      end else if (state == KMS_SCAN && tick && flat == 8'(k)) begin
        if (cur_hit == key_state[k]) begin
          db_cnt[k] <= '0;
        end else if (db_done) begin
          db_cnt[k]    <= '0;
          key_state[k] <= cur_hit;
          // Ghost keys stay locked until released, sparing other keys.
          key_lock[k]  <= cur_hit & (ghost_now | key_lock[k]);
        end else begin
          db_cnt[k] <= db_cnt[k] + 1'b1;
        end
      end
    end
  end

  // Key code buffer write; a full buffer drops the code.
  always_ff @(posedge core_clk) begin
    if (push && fill < 5'(BUF_DEPTH)) begin
      buf_mem[wr_ptr] <= '{release_evt: ~cur_hit, index: key_idx};
    end
  end

  // Buffer pointers; entries leave only on a host read.
  logic pop;
  assign pop = apb_rd && hit(paddr, OFS_DATA) && (fill != '0);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push && fill < 5'(BUF_DEPTH)) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      fill <= fill + 5'(push && fill < 5'(BUF_DEPTH)) - 5'(pop);
    end
  end

  // Sticky flags: hardware set wins over a software clear.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ovf   <= 1'b0;
      ghost <= 1'b0;
    end else begin
      if (push && fill == 5'(BUF_DEPTH)) begin
        ovf <= 1'b1;
      end else if (apb_wr && hit(paddr, OFS_STATUS) && pwdata[ST_OVF_BIT]) begin
        ovf <= 1'b0;
      end
      if (ghost_now) begin
        ghost <= 1'b1;
      end else if (apb_wr && hit(paddr, OFS_STATUS) && pwdata[ST_GHOST_BIT]) begin
        ghost <= 1'b0;
      end
    end
  end

  // Configuration writes; row and column counts are clamped to the matrix.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_rows <= RST_ROWS;
      cfg_cols <= RST_COLS;
      cfg_en   <= 1'b0;
      mod_mask <= '0;
    end else if (apb_wr) begin
      if (hit(paddr, OFS_CTRL)) begin
        cfg_rows <= (pwdata[CTRL_ROWS_LSB+:4] == '0) ? 4'h1 :
                    (pwdata[CTRL_ROWS_LSB+:4] > RST_ROWS) ? RST_ROWS : pwdata[CTRL_ROWS_LSB+:4];
        cfg_cols <= (pwdata[CTRL_COLS_LSB+:5] == '0) ? 5'h01 :
                    (pwdata[CTRL_COLS_LSB+:5] > RST_COLS) ? RST_COLS : pwdata[CTRL_COLS_LSB+:5];
        cfg_en   <= pwdata[CTRL_EN_BIT];
      end
      if (hit(paddr, OFS_MOD0)) begin
        mod_mask[31:0] <= pwdata;
      end
      if (hit(paddr, OFS_MOD1)) begin
        mod_mask[63:32] <= pwdata;
      end
    end
  end

  // Read mux; the status word is what firmware polls.
  logic [31:0] next_prdata;
  logic        next_err;
  always_comb begin
    next_prdata = '0;
    next_err    = 1'b0;
    case (paddr)
      OFS_CTRL: begin
        next_prdata[CTRL_ROWS_LSB+:4] = cfg_rows;
        next_prdata[CTRL_COLS_LSB+:5] = cfg_cols;
        next_prdata[CTRL_EN_BIT]      = cfg_en;
      end
      OFS_STATUS: begin
        next_prdata[ST_CNT_LSB+:5]   = fill;
        next_prdata[ST_EMPTY_BIT]    = (fill == '0);
        next_prdata[ST_FULL_BIT]     = (fill == 5'(BUF_DEPTH));
        next_prdata[ST_OVF_BIT]      = ovf;
        next_prdata[ST_GHOST_BIT]    = ghost;
        next_prdata[ST_ACT_BIT]      = (key_state != '0);
        next_prdata[ST_CLKR_BIT]     = lsclk_req;
        next_prdata[ST_STATE_LSB+:2] = state;
      end
      OFS_DATA: begin
        if (fill != '0) begin
          next_prdata[8:0] = buf_mem[rd_ptr];
        end
      end
      OFS_MOD0: next_prdata = mod_mask[31:0];
      OFS_MOD1: next_prdata = mod_mask[63:32];
      default:  next_err    = 1'b1;
    endcase
  end

  // Registered answer: pready rises in the first access cycle.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      prdata  <= next_prdata;
      pslverr <= psel & ~penable & next_err;
    end
  end

endmodule : kms_scanner

// ### testbench/kms_assertions.sv
// Port-level checker for the key matrix scanner.
`timescale 1ns/100ps
module kms_assertions
  import kms_pkg::*;
#(
  parameter int unsigned TICK_DIV = 4
) (
  // Clock, reset and bus.
  input wire logic                core_clk,
  input wire logic                arst_n,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  // Matrix and clock request.
  input wire logic [MAX_COLS-1:0] col_drive,
  input wire logic [MAX_ROWS-1:0] row_in,
  input wire logic                lsclk_busy,
  input wire logic                lsclk_req
);
  logic [MAX_COLS-1:0] prev_col;
  logic [15:0]         hold_cnt;
  logic                map_hit;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // Offsets that the register map answers; anything else must be refused.
  assign map_hit = paddr inside {OFS_CTRL, OFS_STATUS, OFS_DATA, OFS_MOD0, OFS_MOD1};

  // Counts how long the column pattern has stood, so a short scan step is caught.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_col <= '1;
      hold_cnt <= 16'h0000;
    end else begin
      prev_col <= col_drive;
      hold_cnt <= (col_drive != prev_col) ? 16'h0000 : hold_cnt + 16'h0001;
    end
  end

  ready_timing_a: assert property (psel && !penable |=> pready) else $error("no ready in access cycle");
  err_ready_a: assert property (pslverr |-> pready && psel && penable) else $error("stray error");
  unmapped_err_a: assert property (psel && !penable && !map_hit |=> pslverr) else $error("unmapped accepted");
  mapped_ok_a: assert property (psel && !penable && map_hit |=> !pslverr) else $error("mapped refused");
  idle_cols_a: assert property ((lsclk_busy && !lsclk_req) [*3] |-> &col_drive) else $error("idle cols");
  onehot_scan_a: assert property (!(&col_drive) |-> $onehot(col_drive)) else $error("cols not one-hot");
  col_hold_a: assert property ((col_drive != prev_col) && $onehot(prev_col) |-> hold_cnt >= TICK_DIV - 1)
    else $error("column step too short");
  req_scan_a: assert property (!(&col_drive) && lsclk_busy |-> ##[0:2] lsclk_req) else $error("no request");

  // Main scenarios reached.
  cover property ($fell(&col_drive));
  cover property ($fell(lsclk_req));
  cover property (pready && pslverr);
endmodule : kms_assertions

// ### testbench/kms_key_matrix.sv
// Passive key switch matrix as seen from the scanner pins.
`timescale 1ns/100ps
module kms_key_matrix
  import kms_pkg::*;
(
  // Column drive and switch closures, key index col*8+row.
  input  wire logic [MAX_COLS-1:0]          col_drive,
  input  wire logic [MAX_COLS*MAX_ROWS-1:0] keys,
  // Row lines back to the scanner.
  output logic      [MAX_ROWS-1:0]          row_in
);
  // A closed switch joins a driven column to its row; open rows rest at the pull-down level.
  always_comb begin
    row_in = '0;
    for (int c = 0; c < MAX_COLS; c++) begin
      for (int r = 0; r < MAX_ROWS; r++) begin
        row_in[r] = row_in[r] | (col_drive[c] & keys[c*MAX_ROWS+r]);
      end
    end
  end
endmodule : kms_key_matrix

// ### testbench/tb_key_matrix_scanner.sv
// Self-checking bench for the key matrix scanner.
`timescale 1ns/100ps
module tb_key_matrix_scanner
  import kms_pkg::*;
;
  logic                         core_clk, arst_n, psel, penable, pwrite, pready, pslverr, lsclk_busy, lsclk_req, err;
  logic [7:0]                   paddr, row_in;
  logic [31:0]                  pwdata, prdata, rd;
  logic [MAX_COLS-1:0]          col_drive;
  logic [MAX_COLS*MAX_ROWS-1:0] keys;
  int                           bad_count, cmp_count, seed, k, i;

  // Six clocks per step is the shortest that lets a column settle through the synchroniser.
  kms_scanner #(.DEBOUNCE_SCANS(3), .TICK_DIV(6)) dut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .col_drive(col_drive), .row_in(row_in), .lsclk_busy(lsclk_busy), .lsclk_req(lsclk_req));
  kms_key_matrix u_mx (.col_drive(col_drive), .keys(keys), .row_in(row_in));

  // Free-running 25 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One bus transfer; the slave sets the pace, only the watchdog ends a hang.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Polls status until the masked field matches, with a bounded number of polls.
  task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      repeat (8) @(posedge core_clk);
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while ((rd & m) !== v && n < 800);
    check(rd & m, v);
  endtask : wait_st

  // Expected data word for one key event.
  function automatic logic [31:0] code_of(input logic rel, input int idx);
    kms_code_t c;
    c.release_evt = rel;
    c.index = idx[7:0];
    return {23'h0, c};
  endfunction : code_of

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // Hang guard, well beyond the few tens of thousands of cycles the tests need.
  initial begin
    repeat (100000) @(posedge core_clk);
    bad_count++;
    complete_run();
  end

  initial begin
    seed = 61755;
    {psel, penable, pwrite, paddr, pwdata, keys, arst_n} = '0;
    lsclk_busy = 1'b1;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    check(rd, 32'h148);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd, 32'h100);
    apb(1'b1, 8'h14, 32'hFFFF_FFFF);
    check({31'h0, err}, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b0, OFS_CTRL, 32'h0);
    check(rd, 32'h11);
    apb(1'b1, OFS_CTRL, 32'h1FF);
    apb(1'b0, OFS_CTRL, 32'h0);
    check(rd, 32'h148);
    for (i = 0; i < 6; i++) begin
      k = {$unsigned($random(seed)) % 20 + 1, 4'h0} + $unsigned($random(seed)) % 8 + 1;
      apb(1'b1, OFS_CTRL, k);
      apb(1'b0, OFS_CTRL, 32'h0);
      check(rd, k);
    end
    $display("test registers done");
    // Random single keys: press code, release code, then back to idle with the request dropped.
    apb(1'b1, OFS_MOD0, 32'h0);
    apb(1'b1, OFS_MOD1, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h1148);
    for (i = 0; i < 3; i++) begin
      k = $unsigned($random(seed)) % 160;
      keys[k] <= 1'b1;
      wait_st(32'h1F, 32'h1);
      apb(1'b0, OFS_DATA, 32'h0);
      check(rd, code_of(1'b0, k));
      keys[k] <= 1'b0;
      wait_st(32'h1F, 32'h1);
      apb(1'b0, OFS_DATA, 32'h0);
      check(rd, code_of(1'b1, k));
      wait_st(32'h32000, 32'h0);
    end
    $display("test single keys done");
    // Modifier key 5 held together with key 9: only key 9 is buffered.
    apb(1'b1, OFS_MOD0, 32'h20);
    keys[5] <= 1'b1;
    keys[9] <= 1'b1;
    wait_st(32'h1F, 32'h1);
    apb(1'b0, OFS_DATA, 32'h0);
    check(rd, code_of(1'b0, 9));
    keys[5] <= 1'b0;
    keys[9] <= 1'b0;
    wait_st(32'h3211F, 32'h1);
    apb(1'b0, OFS_DATA, 32'h0);
    check(rd, code_of(1'b1, 9));
    $display("test modifier done");
    // Two rows and three columns: key 5 lies outside the bound, key 17 inside.
    apb(1'b1, OFS_CTRL, 32'h1032);
    keys[5] <= 1'b1;
    keys[17] <= 1'b1;
    wait_st(32'h1F, 32'h1);
    apb(1'b0, OFS_DATA, 32'h0);
    check(rd, code_of(1'b0, 17));
    keys <= '0;
    wait_st(32'h32000, 32'h0);
    apb(1'b0, OFS_DATA, 32'h0);
    check(rd, code_of(1'b1, 17));
    $display("test bounds done");
    // Rectangle of three keys makes a ghost; flag is cleared by writing one.
    apb(1'b1, OFS_CTRL, 32'h1148);
    keys[0] <= 1'b1;
    keys[1] <= 1'b1;
    keys[8] <= 1'b1;
    wait_st(32'h800, 32'h800);
    keys <= '0;
    wait_st(32'h32000, 32'h0);
    apb(1'b1, OFS_STATUS, 32'h800);
    for (i = 0; i < 20; i++) apb(1'b0, OFS_DATA, 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd & 32'hB1F, 32'h100);
    $display("test ghost done");
    // Seventeen keys, one per column: sixteen kept in order, the last dropped with overflow.
    for (i = 0; i < 17; i++) keys[i*8+i%8] <= 1'b1;
    wait_st(32'h61F, 32'h610);
    for (i = 0; i < 16; i++) begin
      apb(1'b0, OFS_DATA, 32'h0);
      check(rd, code_of(1'b0, i*8+i%8));
    end
    apb(1'b0, OFS_DATA, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, OFS_STATUS, 32'h400);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd & 32'h71F, 32'h100);
    $display("test overflow done");
    complete_run();
  end
endmodule : tb_key_matrix_scanner

bind kms_scanner kms_assertions #(.TICK_DIV(TICK_DIV)) u_chk (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .col_drive(col_drive), .row_in(row_in), .lsclk_busy(lsclk_busy), .lsclk_req(lsclk_req));
